// file: verilog/pne_top.sv
// next page received word and eee advertisement status bank for one phy port
// assumes auto-negotiation strobes and words come from logic on i_mclk
`timescale 1ns/1ps
`include "pne_params.svh"
module pne_top
  import pne_pkg::*;
#(
  parameter int CONSIST_BURSTS = `PNE_CONSIST_BURSTS
)(
  input  wire logic                     i_mclk,         // core clock, 100 mhz
  input  wire logic                     i_rst,          // sync reset, high
  input  wire pne_reg_req_t             i_reg_req,      // host register request
  input  wire logic                     i_an_restart,   // auto-negotiation restart
  input  wire logic                     i_flp_valid,    // received burst strobe
  input  wire logic [15:0]              i_flp_word,     // received burst code word
  input  wire logic                     i_base_done,    // base page exchange finished
  input  wire logic [15:0]              i_base_word,    // local base link code word
  input  wire logic                     i_np_sent,      // local next page exchanged
  input  wire logic                     i_np_pending,   // local next page to send
  input  wire logic                     i_lp_eee_valid, // partner eee ability strobe
  input  wire logic [`PNE_LP_EEE_W-1:0] i_lp_eee,       // partner eee kr..tx
  input  wire logic [`PNE_LOC_EEE_W-1:0] i_loc_eee,     // local eee kr, kx4
  output logic [15:0]                   o_reg_rdata,    // read data
  output logic                          o_reg_rack,     // read answer strobe
  output logic                          o_reg_wack,     // write answer strobe
  output logic                          o_tx_ack,       // ack bit for local word
  output logic                          o_tx_toggle,    // toggle bit for local page
  output logic                          o_toggle_err,   // partner toggle out of step
  output logic                          o_np_phase      // next page exchange active
);
  pne_np_state_t state_ff, nxt_state;          // exchange phase
  pne_np_word_t  np_word_ff, nxt_np_word;      // received next page word
  logic [`PNE_LP_EEE_W-1:0]  lp_eee_ff,  nxt_lp_eee;   // partner eee bits
  logic [`PNE_LOC_EEE_W-1:0] loc_eee_ff, nxt_loc_eee;  // local eee bits
  logic          tx_tog_ff,  nxt_tx_tog;       // local toggle
  logic          rx_tog_ff,  nxt_rx_tog;       // last partner toggle
  logic          tog_err_ff, nxt_tog_err;      // sticky toggle mismatch
  logic          tx_ack_ff,  nxt_tx_ack;       // local ack drive
  logic [15:0]   rdata_ff,   nxt_rdata;        // read data
  logic          rack_ff,    nxt_rack;         // read answer
  logic          wack_ff,    nxt_wack;         // write answer
  logic          cons_pulse;                   // bursts became consistent
  logic          cons_done;                    // consistency held
  logic [15:0]   cons_word;                    // consistent word
  pne_eee_adv_t  adv_view;                     // assembled advertisement
  // word index of each register; byte address bit 0 selects no lane
  localparam logic [6:0] NP_WORD_IDX = 7'(`PNE_NP_WORD_OFF >> 1);  // page word index
  localparam logic [6:0] EEE_ADV_IDX = 7'(`PNE_EEE_ADV_OFF >> 1);  // advertisement index

  // consistency detection over received bursts
  // a page repeated after consistency adds no new pulse; only a
  // differing burst or an auto-negotiation restart can start the next capture
  pne_flp_consist #(
    .W      (16),
    .N      (CONSIST_BURSTS),
    .ACKPOS (`PNE_ACK_BIT)
  ) u_consist (
    .i_mclk    (i_mclk),
    .i_rst     (i_rst),
    .i_restart (i_an_restart),
    .i_valid   (i_flp_valid),
    .i_word    (i_flp_word),
    .o_pulse   (cons_pulse),
    .o_done    (cons_done),
    .o_word    (cons_word)
  );

  // phase, toggles and captured page
  always_comb begin
    nxt_state   = state_ff;
    nxt_np_word = np_word_ff;
    nxt_tx_tog  = tx_tog_ff;
    nxt_rx_tog  = rx_tog_ff;
    nxt_tog_err = tog_err_ff;
    // ack only once consistent and nothing left to send
    nxt_tx_ack  = cons_done && !i_np_pending;
    if (i_an_restart) begin
      // restart drops the exchange; the page register keeps its word
      nxt_state   = PNE_NP_IDLE;
      nxt_tog_err = 1'b0;
    end else begin
      unique case (state_ff)
        PNE_NP_IDLE: begin
          // base page is never stored: the register holds next pages only
          // partner base page: remember its toggle position
          if (cons_pulse) begin
            nxt_rx_tog = cons_word[`PNE_TOGGLE_BIT];
          end
          if (i_base_done) begin
            nxt_state  = PNE_NP_XCHG;
            nxt_tx_tog = ~i_base_word[`PNE_TOGGLE_BIT];
          end
        end
        PNE_NP_XCHG: begin
          // every field of the partner page is kept as received
          if (cons_pulse) begin
            nxt_np_word = pne_np_word_t'(cons_word);
            nxt_rx_tog  = cons_word[`PNE_TOGGLE_BIT];
            // partner must alternate; equal toggle means lost step
            // the error is sticky until restart; reads do not clear it
            if (cons_word[`PNE_TOGGLE_BIT] == rx_tog_ff) begin
              nxt_tog_err = 1'b1;
            end
          end
          // each exchanged page flips the local toggle
          if (i_np_sent) begin
            nxt_tx_tog = ~tx_tog_ff;
          end
        end
        default: begin
          nxt_state = PNE_NP_IDLE;         // illegal code recovers to idle
        end
      endcase
    end
  end

  // eee ability capture; partner bits held until a new report
  always_comb begin
    nxt_lp_eee  = lp_eee_ff;
    nxt_loc_eee = i_loc_eee;
    if (i_an_restart) begin
      // restart forgets the partner abilities
      nxt_lp_eee = '0;
    end else if (i_lp_eee_valid) begin
      // report held until the next strobe
      nxt_lp_eee = i_lp_eee;
    end
  end

  // advertisement view, reserved fields tied low
  // low bits 4-0 are not carried by this block and read zero
  always_comb begin
    adv_view          = pne_eee_adv_t'(`PNE_EEE_RESET);
    adv_view.lp_eee   = lp_eee_ff;
    adv_view.loc_eee  = loc_eee_ff;
    adv_view.rsvd_15  = 1'b0;
    adv_view.rsvd_8_7 = 2'b00;
  end

  // register port; writes only answered, nothing stored
  always_comb begin
    nxt_rdata = rdata_ff;
    nxt_rack  = 1'b0;
    nxt_wack  = i_reg_req.wr && !i_reg_req.rd;
    if (i_reg_req.rd) begin
      // rd with wr counts as a read only; that write gets no answer
      nxt_rack = 1'b1;
      // word decode, byte address bit 0 ignored
      unique case (i_reg_req.addr[7:1])
        NP_WORD_IDX: nxt_rdata = 16'(np_word_ff);
        EEE_ADV_IDX: nxt_rdata = 16'(adv_view);
        default:     nxt_rdata = `PNE_RDATA_IDLE;               // unmapped reads zero
      endcase
    end
  end

  // exchange group: phase, captured page, toggles, ack
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      // reset: idle phase, page reads zero
      state_ff   <= PNE_NP_IDLE;
      np_word_ff <= pne_np_word_t'(`PNE_NP_RESET);
      tx_tog_ff  <= 1'b0;
      rx_tog_ff  <= 1'b0;
      tog_err_ff <= 1'b0;
      tx_ack_ff  <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      np_word_ff <= nxt_np_word;
      tx_tog_ff  <= nxt_tx_tog;
      rx_tog_ff  <= nxt_rx_tog;
      tog_err_ff <= nxt_tog_err;
      tx_ack_ff  <= nxt_tx_ack;
    end
  end

  // eee group: both ability fields read zero after reset
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      lp_eee_ff  <= '0;
      loc_eee_ff <= '0;
    end else begin
      // local bits follow the pin level one cycle late
      lp_eee_ff  <= nxt_lp_eee;
      loc_eee_ff <= nxt_loc_eee;
    end
  end

  // register port group: answers are single-cycle strobes
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      // no answer is given while reset is held
      rdata_ff <= `PNE_RDATA_IDLE;
      rack_ff  <= 1'b0;
      wack_ff  <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      rack_ff  <= nxt_rack;
      wack_ff  <= nxt_wack;
    end
  end

  // outputs straight from flops
  // register port answers
  assign o_reg_rdata  = rdata_ff;
  assign o_reg_rack   = rack_ff;
  assign o_reg_wack   = wack_ff;
  // auto-negotiation side
  assign o_tx_ack     = tx_ack_ff;
  assign o_tx_toggle  = tx_tog_ff;
  assign o_toggle_err = tog_err_ff;
  assign o_np_phase   = state_ff[1];
endmodule : pne_top

// file: verilog/pne_params.svh
// offsets, field positions, reset values and counts for the next page / eee status bank
// assumes inclusion by bare name from the design modules
`ifndef PNE_PARAMS_SVH
`define PNE_PARAMS_SVH
`define PNE_NP_WORD_OFF    8'hEA
`define PNE_EEE_ADV_OFF    8'hEC
`define PNE_NP_RESET       16'h0000
`define PNE_EEE_RESET      16'h0000
`define PNE_RDATA_IDLE     16'h0000
`define PNE_ACK_BIT        14
`define PNE_TOGGLE_BIT     11
`define PNE_LP_EEE_W       6
`define PNE_LOC_EEE_W      2
`define PNE_CONSIST_BURSTS 3
`endif

// file: verilog/pne_pkg.sv
// types shared by the next page / eee status bank
// assumes the params header sits beside it
package pne_pkg;
  // received next page code word layout
  typedef struct packed {
    logic        more_pages;
    logic        page_ack;
    logic        message_flag;
    logic        comply_ack;
    logic        sync_toggle;
    logic [10:0] code_field;
  } pne_np_word_t;

  // eee advertisement layout, low bits not carried here read zero
  typedef struct packed {
    logic       rsvd_15;
    logic [5:0] lp_eee;
    logic [1:0] rsvd_8_7;
    logic [1:0] loc_eee;
    logic [4:0] rsvd_low;
  } pne_eee_adv_t;

  // register port request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } pne_reg_req_t;

  // next page exchange phase
  typedef enum logic [1:0] {
    PNE_NP_IDLE = 2'b01,
    PNE_NP_XCHG = 2'b10
  } pne_np_state_t;
endpackage : pne_pkg

// file: verilog/pne_flp_consist.sv
// detects consecutive consistent flp bursts, ack bit ignored
// assumes bursts arrive as one-cycle strobes on the core clock
`timescale 1ns/1ps
module pne_flp_consist
  import pne_pkg::*;
#(
  parameter int W      = 16,
  parameter int N      = 3,
  parameter int ACKPOS = 14
)(
  input  wire logic         i_mclk,        // core clock
  input  wire logic         i_rst,         // sync reset, high
  input  wire logic         i_restart,     // new exchange, forget history
  input  wire logic         i_valid,       // burst strobe
  input  wire logic [W-1:0] i_word,        // burst code word
  output logic              o_pulse,       // first reach of n matches
  output logic              o_done,        // n matches held
  output logic [W-1:0]      o_word         // word that matched
);
  localparam int CW = $clog2(N + 1);
  localparam logic [CW-1:0] CNT_N = CW'(N);
  localparam logic [W-1:0]  MASK  = ~(W'(1) << ACKPOS);

  logic [CW-1:0] cnt_ff,   nxt_cnt;       // consistent burst count
  logic [W-1:0]  word_ff,  nxt_word;      // last burst seen
  logic          pulse_ff, nxt_pulse;     // reach strobe

  // count matches; a differing burst restarts at one
  always_comb begin
    nxt_cnt   = cnt_ff;
    nxt_word  = word_ff;
    nxt_pulse = 1'b0;
    if (i_restart) begin
      nxt_cnt = '0;
    end else if (i_valid) begin
      nxt_word = i_word;
      if (cnt_ff != '0 && ((i_word & MASK) == (word_ff & MASK))) begin
        if (cnt_ff != CNT_N) begin
          nxt_cnt   = cnt_ff + CW'(1);
          nxt_pulse = (cnt_ff + CW'(1)) == CNT_N;
        end
      end else begin
        nxt_cnt = CW'(1);                  // a mismatch is the new first burst
      end
    end
  end

  // register only
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cnt_ff   <= '0;
      word_ff  <= '0;
      pulse_ff <= 1'b0;
    end else begin
      cnt_ff   <= nxt_cnt;
      word_ff  <= nxt_word;
      pulse_ff <= nxt_pulse;
    end
  end

  assign o_pulse = pulse_ff;
  assign o_done  = (cnt_ff == CNT_N);
  assign o_word  = word_ff;
endmodule : pne_flp_consist

// file: bench/pne_lp_model.sv
// link partner model: sends each code word as three consistent bursts
// assumes the bench calls send() and the dut samples on rising i_mclk
`timescale 1ns/1ps
module pne_lp_model (
  input  wire logic        i_mclk,      // core clock
  output logic             o_flp_valid, // burst strobe
  output logic [15:0]      o_flp_word   // burst code word
);
  logic tgl = 1'b0; // toggle owed on the next page
  initial begin
    o_flp_valid = 1'b0;
    o_flp_word  = 16'h0000;
  end
  // bad repeats the last toggle, only when a scenario asks for it
  task automatic send(input logic [15:0] w, input bit base, input bit bad);
    logic [15:0] x;
    x = w;
    if (!base) begin
      x[11] = bad ? !tgl : tgl;
    end
    repeat (3) begin
      @(posedge i_mclk);
      #1;
      o_flp_valid = 1'b1;
      o_flp_word  = x;
    end
    @(posedge i_mclk);
    #1;
    o_flp_valid = 1'b0;
    o_flp_word  = ~x; // released word is not held
    tgl = !x[11];
  endtask : send
endmodule : pne_lp_model

// file: bench/pne_top_sva.sv
// port checker for the next page / eee status bank
// assumes it is bound onto pne_top
`timescale 1ns/1ps
module pne_top_sva
  import pne_pkg::*;
#(
  parameter int CONSIST_BURSTS = 3
)(
  input wire logic         i_mclk,
  input wire logic         i_rst,
  input wire pne_reg_req_t i_reg_req,
  input wire logic         i_an_restart,
  input wire logic         i_flp_valid,
  input wire logic [15:0]  i_flp_word,
  input wire logic         i_base_done,
  input wire logic [15:0]  i_base_word,
  input wire logic         i_np_sent,
  input wire logic         i_np_pending,
  input wire logic         i_lp_eee_valid,
  input wire logic [5:0]   i_lp_eee,
  input wire logic [1:0]   i_loc_eee,
  input wire logic [15:0]  o_reg_rdata,
  input wire logic         o_reg_rack,
  input wire logic         o_reg_wack,
  input wire logic         o_tx_ack,
  input wire logic         o_tx_toggle,
  input wire logic         o_toggle_err,
  input wire logic         o_np_phase
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  wire logic rd_np = i_reg_req.rd && i_reg_req.addr[7:1] == 7'h75; // page word read
  wire logic rd_ee = i_reg_req.rd && i_reg_req.addr[7:1] == 7'h76; // eee read
  logic [15:0] last_w_ff; // last burst word
  always_ff @(posedge i_mclk) begin
    if (i_flp_valid) last_w_ff <= i_flp_word;
  end
  // ack bit ignored when comparing bursts
  sequence s_same;
    i_flp_valid && !i_an_restart && (i_flp_word & 16'hBFFF) == ($past(i_flp_word) & 16'hBFFF);
  endsequence
  sequence s_three;
    (i_flp_valid && !i_an_restart) ##1 s_same [*2];
  endsequence
  sequence s_quiet;
    !i_flp_valid && !i_an_restart;
  endsequence
  rd_ack_a: assert property (i_reg_req.rd |=> o_reg_rack && !o_reg_wack)
    else $error("read answer wrong");
  wr_ack_a: assert property (i_reg_req.wr && !i_reg_req.rd |=> o_reg_wack && !o_reg_rack)
    else $error("write answer wrong");
  rsvd_zero_a: assert property (rd_ee |=> (o_reg_rdata & 16'h819F) == 16'h0000)
    else $error("reserved bits set");
  lp_eee_a: assert property ((i_lp_eee_valid && !i_an_restart)
    ##1 (!i_lp_eee_valid && !i_an_restart) [*2] ##0 rd_ee
    |=> o_reg_rdata[14:9] == $past(i_lp_eee, 3))
    else $error("partner eee bits wrong");
  loc_eee_a: assert property (rd_ee && !$past(i_rst)
    |=> o_reg_rdata[6:5] == $past(i_loc_eee, 2))
    else $error("local eee bits wrong");
  ack_gate_a: assert property (o_tx_ack |-> !$past(i_np_pending))
    else $error("ack while page pending");
  ack_three_a: assert property (s_three ##1 (s_quiet and !i_np_pending) |=> o_tx_ack)
    else $error("ack missing after bursts");
  page_word_a: assert property (o_np_phase ##0 s_three
    ##1 s_quiet [*2] ##0 rd_np
    |=> o_reg_rdata == last_w_ff)
    else $error("page word wrong");
  toggle_init_a: assert property (i_base_done && !i_an_restart
    |=> o_np_phase && o_tx_toggle == !$past(i_base_word[11]))
    else $error("first toggle wrong");
  toggle_flip_a: assert property (o_np_phase && i_np_sent
    && !i_base_done && !i_an_restart
    |=> o_tx_toggle != $past(o_tx_toggle))
    else $error("toggle did not flip");
  restart_clr_a: assert property (i_an_restart && !i_base_done
    |=> !o_np_phase && !o_toggle_err)
    else $error("restart left state");
endmodule : pne_top_sva
bind pne_top pne_top_sva #(
  .CONSIST_BURSTS (CONSIST_BURSTS)
) i_sva (
  .i_mclk         (i_mclk),
  .i_rst          (i_rst),
  .i_reg_req      (i_reg_req),
  .i_an_restart   (i_an_restart),
  .i_flp_valid    (i_flp_valid),
  .i_flp_word     (i_flp_word),
  .i_base_done    (i_base_done),
  .i_base_word    (i_base_word),
  .i_np_sent      (i_np_sent),
  .i_np_pending   (i_np_pending),
  .i_lp_eee_valid (i_lp_eee_valid),
  .i_lp_eee       (i_lp_eee),
  .i_loc_eee      (i_loc_eee),
  .o_reg_rdata    (o_reg_rdata),
  .o_reg_rack     (o_reg_rack),
  .o_reg_wack     (o_reg_wack),
  .o_tx_ack       (o_tx_ack),
  .o_tx_toggle    (o_tx_toggle),
  .o_toggle_err   (o_toggle_err),
  .o_np_phase     (o_np_phase)
);

// file: bench/port_autoneg_next_page_eee_status_tb_top.sv
// self-checking bench for the next page / eee status bank
// assumes pne_top, its checker and the partner model are compiled first
`timescale 1ns/1ps
module port_autoneg_next_page_eee_status_tb_top;
  import pne_pkg::*;
  logic         i_mclk = 1'b0;      // core clock
  logic         i_rst  = 1'b1;      // sync reset
  pne_reg_req_t req    = '0;        // host request
  logic         rst_an = 1'b0;      // restart pulse
  logic         bdone  = 1'b0;      // base page done
  logic         nps    = 1'b0;      // page sent pulse
  logic         npp    = 1'b1;      // page pending
  logic         eev    = 1'b0;      // eee strobe
  logic [5:0]   lpe    = 6'h00;     // partner eee
  logic [1:0]   loce   = 2'h0;      // local eee
  logic [15:0]  bw     = 16'h0000;  // local base word
  logic         fv, rack, wack, txa, txt, terr, ph;
  logic [15:0]  fw, rdata;
  int           n_fail  = 0;
  int           checked = 0;
  always #5 i_mclk = ~i_mclk;
  pne_lp_model i_lp (.i_mclk(i_mclk), .o_flp_valid(fv), .o_flp_word(fw));
  pne_top i_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_reg_req(req), .i_an_restart(rst_an),
    .i_flp_valid(fv), .i_flp_word(fw), .i_base_done(bdone), .i_base_word(bw),
    .i_np_sent(nps), .i_np_pending(npp), .i_lp_eee_valid(eev), .i_lp_eee(lpe),
    .i_loc_eee(loce), .o_reg_rdata(rdata), .o_reg_rack(rack), .o_reg_wack(wack),
    .o_tx_ack(txa), .o_tx_toggle(txt), .o_toggle_err(terr), .o_np_phase(ph));
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc();
    @(posedge i_mclk);
    #1;
  endtask : cyc
  // answer is fixed at one cycle, so no open wait
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    cyc();
    req.rd   = 1'b1;
    req.addr = a;
    cyc();
    req.rd = 1'b0;
    chk({rack, rdata}, {1'b1, exp});
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    cyc();
    req.wr    = 1'b1;
    req.addr  = a;
    req.wdata = d;
    cyc();
    req.wr = 1'b0;
    chk({16'h0000, wack}, 17'h00001);
  endtask : wr
  task automatic t_reset();
    rd(8'hEA, 16'h0000);
    rd(8'hEC, 16'h0000);
    rd(8'hF0, 16'h0000);
    chk({13'h0000, txa, txt, terr, ph}, 17'h00000);
  endtask : t_reset
  task automatic t_eee();
    for (int k = 0; k < 6; k++) begin
      cyc();
      eev  = 1'b1;
      lpe  = 6'h01 << k;
      loce = k[1:0];
      cyc();
      eev = 1'b0;
      rd(8'hEC, {1'b0, lpe, 2'h0, loce, 5'h00});
    end
    wr(8'hED, 16'hFFFF);
    rd(8'hED, 16'h4020);
  endtask : t_eee
  task automatic t_pages();
    i_lp.send(16'h0800, 1'b1, 1'b0);
    cyc();
    bdone = 1'b1;
    cyc();
    bdone = 1'b0;
    cyc();
    chk({15'h0000, ph, txt}, 17'h00003);
    i_lp.send(16'hA5A5, 1'b0, 1'b0);
    rd(8'hEA, 16'hA5A5);
    chk({16'h0000, txa}, 17'h00000);
    cyc();
    nps = 1'b1;
    cyc();
    nps = 1'b0;
    cyc();
    chk({16'h0000, txt}, 17'h00000);
    npp = 1'b0;
    i_lp.send(16'h5FFF, 1'b0, 1'b0);
    rd(8'hEB, 16'h5FFF);
    chk({15'h0000, txa, terr}, 17'h00002);
    wr(8'hEA, 16'h0000);
    rd(8'hEA, 16'h5FFF);
    i_lp.send(16'h0000, 1'b0, 1'b1);
    rd(8'hEA, 16'h0800);
    chk({16'h0000, terr}, 17'h00001);
    cyc();
    rst_an = 1'b1;
    cyc();
    rst_an = 1'b0;
    cyc();
    chk({14'h0000, txa, ph, terr}, 17'h00000);
    rd(8'hEC, 16'h0020);
    bw = 16'h0800;
    cyc();
    bdone = 1'b1;
    cyc();
    bdone = 1'b0;
    cyc();
    chk({15'h0000, ph, txt}, 17'h00002);
    nps = 1'b1;
    cyc();
    nps = 1'b0;
    cyc();
    chk({16'h0000, txt}, 17'h00001);
  endtask : t_pages
  task automatic tally_and_finish();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  // watchdog so a hang still reaches the report
  initial begin
    #100000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge i_mclk);
    #1;
    i_rst = 1'b0;
    t_reset();
    t_eee();
    t_pages();
    tally_and_finish();
  end
endmodule : port_autoneg_next_page_eee_status_tb_top
